// [rtl/dtwoc_map.svh]
// Register offsets, field positions, reset values and timing counts.
// Assumes nothing; included by every design file that needs a figure.
`ifndef DTWOC_MAP_SVH
`define DTWOC_MAP_SVH
// ------------------------------------------------------------
// Channels and switch contacts
// ------------------------------------------------------------
`define DTWOC_NCH 2
`define DTWOC_NSW 8
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define DTWOC_CLK_HZ 50000000
`define DTWOC_TICK_US 1000
`define DTWOC_TICK_CYCLES (`DTWOC_CLK_HZ / 1000000 * `DTWOC_TICK_US)
`define DTWOC_DEB_MS 10
`define DTWOC_DEB_TICKS (`DTWOC_DEB_MS * 1000 / `DTWOC_TICK_US)
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define DTWOC_ADDR_CTRL 6'h00
`define DTWOC_ADDR_TRIP0 6'h04
`define DTWOC_ADDR_TRIP1 6'h08
`define DTWOC_ADDR_STATUS 6'h0c
`define DTWOC_ADDR_IRQ_STAT 6'h10
`define DTWOC_ADDR_IRQ_MASK 6'h14
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define DTWOC_CTRL_START_LSB 0
`define DTWOC_STAT_OUT_LSB 0
`define DTWOC_STAT_BLOWN_LSB 2
`define DTWOC_STAT_ACC_BIT 4
`define DTWOC_STAT_IGN_BIT 5
`define DTWOC_IRQ_ON_LSB 0
`define DTWOC_IRQ_OFF_LSB 2
`define DTWOC_IRQ_TRIP_LSB 4
// ------------------------------------------------------------
// Reset values and limits (trip level in tenths of an amp)
// ------------------------------------------------------------
`define DTWOC_CTRL_RST 2'h0
`define DTWOC_TRIP_RST 8'hc8
`define DTWOC_TRIP_MAX 8'hc8
`define DTWOC_MASK_RST 6'h00
`endif

// [rtl/dtwoc_pkg.sv]
// Types shared by the output-control design files.
// Assumes the map header for widths.
`include "dtwoc_map.svh"
package dtwoc_pkg;
    typedef logic [7:0] dtwoc_amp_t;
    typedef logic [`DTWOC_NCH-1:0] dtwoc_ch_t;
    typedef enum logic {BUS_IDLE, BUS_ACK} dtwoc_bus_e;
endpackage

// [rtl/dtwoc_sw_if.sv]
// Carrier between the top and the switch debouncer.
// Assumes one clock; tick is a one-cycle enable.
`timescale 1ns/1ps
`include "dtwoc_map.svh"
interface dtwoc_sw_if;
    logic [`DTWOC_NSW-1:0] raw;
    logic tick;
    logic [`DTWOC_NSW-1:0] level;
    logic [`DTWOC_NSW-1:0] rise;
    modport deb (input raw, input tick, output level, output rise);
    modport user (output raw, output tick, input level, input rise);
endinterface

// [rtl/dtwoc_debounce.sv]
// Synchroniser and tick-based debouncer for every switch contact.
// Assumes tick pulses once per millisecond from the top's divider.
`timescale 1ns/1ps
`include "dtwoc_map.svh"
module dtwoc_debounce
    import dtwoc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // Switch carrier
    dtwoc_sw_if.deb sw
);
    genvar b;
    generate
        for (b = 0; b < `DTWOC_NSW; b++) begin : g_bit
            logic s1_reg, s2_reg;
            logic [3:0] cnt_reg;
            wire differs = s2_reg != sw.level[b];
            wire settled = differs && sw.tick && (cnt_reg == 4'(`DTWOC_DEB_TICKS - 1));
            always_ff @(posedge i_clk_sys) begin
                s1_reg <= i_srst ? 1'b0 : sw.raw[b];
                s2_reg <= i_srst ? 1'b0 : s1_reg;
            end
            // Contact must hold its new level for the whole window
            always_ff @(posedge i_clk_sys) begin
                if (i_srst || !differs) begin
                    cnt_reg <= 4'h0;
                end else if (sw.tick) begin
                    cnt_reg <= cnt_reg + 4'h1;
                end
            end
            always_ff @(posedge i_clk_sys) begin
                if (i_srst) begin
                    sw.level[b] <= 1'b0;
                    sw.rise[b] <= 1'b0;
                end else begin
                    sw.level[b] <= settled ? s2_reg : sw.level[b];
                    sw.rise[b] <= settled && s2_reg;
                end
            end
        end
    endgenerate
endmodule // dtwoc_debounce

// [rtl/dtwoc_fuse.sv]
// Virtual fuse: compares sensed current with the trip level per channel.
// Assumes current is sampled in tenths of an amp, same scale as the level.
`timescale 1ns/1ps
`include "dtwoc_map.svh"
module dtwoc_fuse
    import dtwoc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // Current and level
    input wire dtwoc_amp_t [`DTWOC_NCH-1:0] i_current,
    input wire dtwoc_amp_t [`DTWOC_NCH-1:0] i_level,
    // Trip flag, registered; stays high while current exceeds the level
    output logic [`DTWOC_NCH-1:0] o_trip
);
    genvar c;
    generate
        for (c = 0; c < `DTWOC_NCH; c++) begin : g_ch
            wire over = i_current[c] > i_level[c];
            always_ff @(posedge i_clk_sys) begin
                o_trip[c] <= i_srst ? 1'b0 : over;
            end
        end
    endgenerate
endmodule // dtwoc_fuse

// [rtl/dtwoc_top.sv]
// Two-channel three-way output control with Avalon-MM registers.
// Assumes all pins synchronous to i_clk_sys; switch contacts active high.
`timescale 1ns/1ps
`include "dtwoc_map.svh"
module dtwoc_top
    import dtwoc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `DTWOC_TICK_CYCLES
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // Avalon-MM slave
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Key state
    input wire logic i_key_acc,
    input wire logic i_key_ign,
    // Switch contacts
    input wire dtwoc_ch_t i_cab_on,
    input wire dtwoc_ch_t i_cab_off,
    input wire dtwoc_ch_t i_remote_switch_in_hi,
    input wire dtwoc_ch_t i_remote_switch_in_lo,
    // Load current sense, tenths of an amp
    input wire dtwoc_amp_t [`DTWOC_NCH-1:0] i_load_current,
    // Power outputs and lamps
    output dtwoc_ch_t o_channel_power_out,
    output dtwoc_ch_t o_lamp_on,
    // Interrupt
    output logic o_irq
);
    // ------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------
    logic [15:0] tick_cnt_reg;
    wire tick_hit = tick_cnt_reg == 16'(TICK_CYCLES - 1);

    always_ff @(posedge i_clk_sys) begin
        if (i_srst || tick_hit) begin
            tick_cnt_reg <= 16'h0000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Switch debouncing
    // ------------------------------------------------------------
    dtwoc_sw_if sw ();

    assign sw.raw = {i_remote_switch_in_lo, i_remote_switch_in_hi, i_cab_off, i_cab_on};
    assign sw.tick = tick_hit;

    dtwoc_debounce u_debounce (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .sw(sw.deb)
    );

    wire dtwoc_ch_t cab_on_rise = sw.rise[1:0];
    wire dtwoc_ch_t cab_off_rise = sw.rise[3:2];
    // Open remote pin gives neither contact, so no command at all
    wire dtwoc_ch_t rem_on_rise = sw.rise[5:4];
    wire dtwoc_ch_t rem_off_rise = sw.rise[7:6];

    // ------------------------------------------------------------
    // Key state
    // ------------------------------------------------------------
    logic key_on_reg;
    wire key_on = i_key_acc || i_key_ign;
    wire key_rise = key_on && !key_on_reg;

    always_ff @(posedge i_clk_sys) begin
        key_on_reg <= i_srst ? 1'b0 : key_on;
    end

    // ------------------------------------------------------------
    // Avalon-MM slave: one wait state, then the answer
    // ------------------------------------------------------------
    dtwoc_bus_e bus_state_reg;
    dtwoc_bus_e bus_state_next;
    logic [31:0] rdata_reg;
    logic [1:0] start_state_reg;
    dtwoc_amp_t [`DTWOC_NCH-1:0] trip_level_reg;
    logic [5:0] irq_stat_reg;
    logic [5:0] irq_mask_reg;
    dtwoc_ch_t out_reg;
    dtwoc_ch_t blown_reg;

    wire bus_req = i_avs_read || i_avs_write;
    wire bus_acc = bus_req && (bus_state_reg == BUS_ACK);
    wire wr_en = i_avs_write && bus_acc && i_avs_byteenable[0];
    wire sel_ctrl = i_avs_address == `DTWOC_ADDR_CTRL;
    wire sel_trip0 = i_avs_address == `DTWOC_ADDR_TRIP0;
    wire sel_trip1 = i_avs_address == `DTWOC_ADDR_TRIP1;
    wire sel_status = i_avs_address == `DTWOC_ADDR_STATUS;
    wire sel_istat = i_avs_address == `DTWOC_ADDR_IRQ_STAT;
    wire sel_imask = i_avs_address == `DTWOC_ADDR_IRQ_MASK;
    wire [7:0] wbyte = i_avs_writedata[7:0];
    // Levels above 20 A are clamped rather than refused
    wire dtwoc_amp_t trip_wval = (wbyte > `DTWOC_TRIP_MAX) ? `DTWOC_TRIP_MAX : wbyte;
    wire [5:0] status_val = {i_key_ign, i_key_acc, blown_reg, out_reg};
    wire [31:0] rd_mux =
        sel_ctrl ? {30'h0, start_state_reg} :
        sel_trip0 ? {24'h0, trip_level_reg[0]} :
        sel_trip1 ? {24'h0, trip_level_reg[1]} :
        sel_status ? {26'h0, status_val} :
        sel_istat ? {26'h0, irq_stat_reg} :
        sel_imask ? {26'h0, irq_mask_reg} : 32'h0000_0000;

    assign o_avs_waitrequest = bus_req && (bus_state_reg == BUS_IDLE);
    assign o_avs_readdata = rdata_reg;

    always_comb begin
        case (bus_state_reg)
            BUS_IDLE: bus_state_next = bus_req ? BUS_ACK : BUS_IDLE;
            BUS_ACK: bus_state_next = BUS_IDLE;
            default: bus_state_next = BUS_IDLE;
        endcase
    end

    // Read data is captured in the wait cycle so it stands at the answer edge
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            bus_state_reg <= BUS_IDLE;
            rdata_reg <= 32'h0000_0000;
        end else begin
            bus_state_reg <= bus_state_next;
            rdata_reg <= (bus_state_reg == BUS_IDLE) ? rd_mux : rdata_reg;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            start_state_reg <= `DTWOC_CTRL_RST;
            irq_mask_reg <= `DTWOC_MASK_RST;
        end else if (wr_en) begin
            start_state_reg <= sel_ctrl ? wbyte[1:0] : start_state_reg;
            irq_mask_reg <= sel_imask ? wbyte[5:0] : irq_mask_reg;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            trip_level_reg[0] <= `DTWOC_TRIP_RST;
            trip_level_reg[1] <= `DTWOC_TRIP_RST;
        end else if (wr_en) begin
            trip_level_reg[0] <= sel_trip0 ? trip_wval : trip_level_reg[0];
            trip_level_reg[1] <= sel_trip1 ? trip_wval : trip_level_reg[1];
        end
    end

    // ------------------------------------------------------------
    // Virtual fuse
    // ------------------------------------------------------------
    dtwoc_ch_t trip;

    dtwoc_fuse u_fuse (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_current(i_load_current),
        .i_level(trip_level_reg),
        .o_trip(trip)
    );

    // ------------------------------------------------------------
    // Channel latches
    // ------------------------------------------------------------
    dtwoc_ch_t on_req;
    dtwoc_ch_t off_req;
    dtwoc_ch_t out_next;

    genvar c;
    generate
        for (c = 0; c < `DTWOC_NCH; c++) begin : g_ch
            wire cab_on_ok = cab_on_rise[c] && key_on;
            wire start_on = key_rise && start_state_reg[c];
            assign on_req[c] = cab_on_ok || rem_on_rise[c] || start_on;
            assign off_req[c] = cab_off_rise[c] || rem_off_rise[c] || trip[c];
            // Key-off alone never clears the latch
            assign out_next[c] = off_req[c] ? 1'b0 : (on_req[c] ? 1'b1 : out_reg[c]);

            always_ff @(posedge i_clk_sys) begin
                if (i_srst) begin
                    out_reg[c] <= 1'b0;
                    blown_reg[c] <= 1'b0;
                end else begin
                    out_reg[c] <= out_next[c];
                    blown_reg[c] <= trip[c] || (blown_reg[c] && !on_req[c]);
                end
            end
        end
    endgenerate

    assign o_channel_power_out = out_reg;
    assign o_lamp_on = out_reg;

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    wire [5:0] irq_ev = {trip & out_reg, out_reg & ~out_next, out_next & ~out_reg};
    wire [5:0] irq_clr = (wr_en && sel_istat) ? wbyte[5:0] : 6'h00;

    // A new event beats a write-one-to-clear in the same cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            irq_stat_reg <= 6'h00;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
        end
    end

    assign o_irq = |(irq_stat_reg & irq_mask_reg);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_srst);

    generate
        for (c = 0; c < `DTWOC_NCH; c++) begin : g_chk
            a_off_beats_on: assert property (
                off_req[c] && on_req[c] |=> !o_channel_power_out[c])
                else $error("off and on together left output on");
            a_cab_needs_key: assert property (
                !o_channel_power_out[c] && cab_on_rise[c] && !key_on
                && !rem_on_rise[c] && !key_rise |=> !o_channel_power_out[c])
                else $error("cab press with key off turned output on");
            a_remote_any_key: assert property (
                rem_on_rise[c] && !off_req[c] |=> o_channel_power_out[c])
                else $error("remote on press ignored");
            a_keyoff_holds: assert property (
                o_channel_power_out[c] && key_on_reg && !key_on && !off_req[c]
                |=> o_channel_power_out[c])
                else $error("output cleared on key-off");
            a_start_forced: assert property (
                $rose(key_on) && start_state_reg[c] && !off_req[c]
                |=> o_channel_power_out[c])
                else $error("start state did not force output on");
            a_fuse_cuts: assert property (
                i_load_current[c] > trip_level_reg[c] |-> ##2 !o_channel_power_out[c])
                else $error("over-current did not shut output");
            a_latch_holds: assert property (
                !on_req[c] && !off_req[c] |=> $stable(o_channel_power_out[c]))
                else $error("output changed with no command");
            a_lamp_follows: assert property (
                $changed(o_channel_power_out[c]) |-> o_lamp_on[c] == o_channel_power_out[c])
                else $error("lamp differs from output");
            a_trip_range: assert property (
                trip_level_reg[c] <= `DTWOC_TRIP_MAX)
                else $error("trip level above 20 A");
            a_cab_on_taken: assert property (
                cab_on_rise[c] && key_on && !off_req[c] |=> o_channel_power_out[c])
                else $error("cab press with key on ignored");
            a_cab_off_clears: assert property (
                cab_off_rise[c] |=> !o_channel_power_out[c])
                else $error("cab off press left output on");
            a_remote_off_clears: assert property (
                rem_off_rise[c] |=> !o_channel_power_out[c])
                else $error("remote ground press left output on");
            a_press_once: assert property (
                cab_on_rise[c] |=> !cab_on_rise[c])
                else $error("one cab press acted on twice");
            a_blown_marked: assert property (
                trip[c] && out_reg[c] |=> blown_reg[c] && !o_channel_power_out[c])
                else $error("trip did not blow the channel");
            a_start_clear_idle: assert property (
                $rose(key_on) && !start_state_reg[c] && !o_channel_power_out[c]
                && !cab_on_rise[c] && !rem_on_rise[c] |=> !o_channel_power_out[c])
                else $error("output forced on with start state clear");
        end
    endgenerate

    a_bus_one_wait: assert property (
        bus_req && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("answer not given after one wait cycle");
    a_irq_sticky: assert property (
        irq_stat_reg[0] && !(wr_en && sel_istat) |=> irq_stat_reg[0])
        else $error("status bit lost without a clear");
    // Out-of-range writes must land as the 20 A ceiling, never wrap
    a_trip0_clamp: assert property (
        wr_en && sel_trip0 && wbyte > `DTWOC_TRIP_MAX |=> trip_level_reg[0] == `DTWOC_TRIP_MAX)
        else $error("trip level 0 not clamped");
    a_rdata_held: assert property (
        bus_acc |=> $stable(o_avs_readdata))
        else $error("read data moved after the answer");
    a_bus_idle_free: assert property (
        !bus_req |-> !o_avs_waitrequest)
        else $error("wait asserted with no request");
    // A stretched tick would shorten the debounce window
    a_tick_single: assert property (
        tick_hit |=> !tick_hit)
        else $error("divider tick longer than one cycle");

    // Per status bit: a written one clears, an event in the same cycle wins
    genvar b;
    generate
        for (b = 0; b < 6; b++) begin : g_irq_chk
            a_irq_w1c: assert property (
                wr_en && sel_istat && wbyte[b] && !irq_ev[b] |=> !irq_stat_reg[b])
                else $error("written one did not clear its bit");
            a_irq_set_wins: assert property (
                irq_ev[b] |=> irq_stat_reg[b])
                else $error("event lost against a clear");
        end
    endgenerate

    // ------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------
    c_remote_on: cover property (rem_on_rise[0] ##1 o_channel_power_out[0]);
    c_fuse_blown: cover property (trip[1] && out_reg[1] ##1 blown_reg[1]);
    c_start_state: cover property ($rose(key_on) && start_state_reg[0]);
    c_irq_raised: cover property ($rose(o_irq));
    c_off_wins: cover property (off_req[0] && on_req[0]);
endmodule // dtwoc_top

// [testbench/dtwoc_far_side.sv]
// Far-side model: momentary cab and remote switches plus the switched loads.
// Assumes the bench asks for a press with a one-cycle pulse on i_press.
`timescale 1ns/1ps
module dtwoc_far_side
    import dtwoc_pkg::*;
(
    // Clock
    input wire logic i_clk_sys,
    // Bench requests: [1:0] cab on, [3:2] cab off, [5:4] remote high, [7:6] remote ground
    input wire logic [7:0] i_press,
    input wire dtwoc_amp_t [1:0] i_draw,
    input wire dtwoc_ch_t i_power,
    // Contacts and sensed current
    output logic [7:0] o_contact,
    output dtwoc_amp_t [1:0] o_current
);
    int hold [8];
    initial begin
        foreach (hold[i]) hold[i] = 0;
    end
    // A press holds its contact for 100 cycles and chatters for the first five
    always @(posedge i_clk_sys) begin
        for (int i = 0; i < 8; i++) begin
            if (i_press[i]) hold[i] <= 100;
            else if (hold[i] > 0) hold[i] <= hold[i] - 1;
        end
    end
    // Remote pin at 12 V asks for on, at ground asks for off; unpressed leaves both low
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            o_contact[i] = (hold[i] > 95) ? hold[i][0] : (hold[i] > 0);
        end
    end
    // A load draws current only while it is powered
    assign o_current[0] = i_power[0] ? i_draw[0] : 8'h00;
    assign o_current[1] = i_power[1] ? i_draw[1] : 8'h00;
endmodule // dtwoc_far_side

// [testbench/dual_three_way_output_control_test.sv]
// Self-checking bench for the two-channel output control.
// Assumes TICK_CYCLES of 4, so a press settles in well under 220 cycles.
`timescale 1ns/1ps
module dual_three_way_output_control_test
    import dtwoc_pkg::*;
;
    logic i_clk_sys, i_srst, avs_read, avs_write, key_acc, key_ign;
    logic [5:0] avs_address;
    logic [3:0] avs_be;
    logic [31:0] avs_writedata, rd;
    logic [7:0] press;
    dtwoc_amp_t [1:0] draw;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, irq;
    wire [7:0] contact;
    wire dtwoc_amp_t [1:0] current;
    wire dtwoc_ch_t power_out, lamp_on;
    int mismatches, num_checks;

    dtwoc_top #(.TICK_CYCLES(4)) DUT (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
        .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
        .i_avs_byteenable(avs_be), .i_avs_writedata(avs_writedata),
        .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
        .i_key_acc(key_acc), .i_key_ign(key_ign), .i_cab_on(contact[1:0]),
        .i_cab_off(contact[3:2]), .i_remote_switch_in_hi(contact[5:4]),
        .i_remote_switch_in_lo(contact[7:6]), .i_load_current(current),
        .o_channel_power_out(power_out), .o_lamp_on(lamp_on), .o_irq(irq));
    dtwoc_far_side far (.i_clk_sys(i_clk_sys), .i_press(press), .i_draw(draw),
        .i_power(power_out), .o_contact(contact), .o_current(current));

    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Holds the request until waitrequest is sampled low, then releases it
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge i_clk_sys);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge i_clk_sys);
    endtask

    task automatic rdc(input string what, input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask

    task automatic act(input logic [7:0] which);
        press <= which;
        @(posedge i_clk_sys);
        press <= 8'h00;
        repeat (220) @(posedge i_clk_sys);
    endtask

    task automatic outs(input logic [1:0] exp);
        check("power_out", {30'h0, power_out}, {30'h0, exp});
        check("lamp_on", {30'h0, lamp_on}, {30'h0, exp});
    endtask

    task automatic keys(input logic acc, input logic ign);
        key_acc <= acc;
        key_ign <= ign;
        repeat (10) @(posedge i_clk_sys);
    endtask

    task automatic t_reset();
        rdc("ctrl", 6'h00, 32'h0);
        rdc("trip0", 6'h04, 32'hc8);
        rdc("trip1", 6'h08, 32'hc8);
        rdc("mask", 6'h14, 32'h0);
        rdc("unmapped", 6'h20, 32'h0);
        outs(2'b00);
        check("irq", {31'h0, irq}, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_cab();
        act(8'h01);
        outs(2'b00);
        keys(1'b1, 1'b0);
        act(8'h01);
        outs(2'b01);
        act(8'h04);
        outs(2'b00);
        keys(1'b0, 1'b1);
        act(8'h02);
        outs(2'b10);
        act(8'h08);
        outs(2'b00);
        keys(1'b0, 1'b0);
        $display("test cab done");
    endtask

    task automatic t_remote();
        act(8'h10);
        outs(2'b01);
        keys(1'b0, 1'b1);
        keys(1'b0, 1'b0);
        outs(2'b01);
        act(8'h40);
        outs(2'b00);
        act(8'h20);
        outs(2'b10);
        act(8'h80);
        outs(2'b00);
        $display("test remote done");
    endtask

    task automatic t_off_wins();
        keys(1'b1, 1'b1);
        act(8'h01);
        outs(2'b01);
        act(8'h41);
        outs(2'b00);
        act(8'h28);
        outs(2'b00);
        keys(1'b0, 1'b0);
        $display("test off_wins done");
    endtask

    task automatic t_start();
        bus(1'b1, 6'h00, 32'h3);
        avs_be <= 4'he;
        bus(1'b1, 6'h00, 32'h0);
        avs_be <= 4'hf;
        rdc("ctrl", 6'h00, 32'h3);
        keys(1'b1, 1'b0);
        outs(2'b11);
        keys(1'b0, 1'b0);
        outs(2'b11);
        act(8'hc0);
        outs(2'b00);
        bus(1'b1, 6'h00, 32'h0);
        keys(1'b0, 1'b1);
        outs(2'b00);
        $display("test start done");
    endtask

    task automatic t_fuse();
        bus(1'b1, 6'h04, 32'hd0);
        rdc("trip0 clamp", 6'h04, 32'hc8);
        bus(1'b1, 6'h04, 32'h32);
        rdc("trip0", 6'h04, 32'h32);
        bus(1'b1, 6'h14, 32'h10);
        draw[0] <= 8'h32;
        act(8'h01);
        outs(2'b01);
        check("irq idle", {31'h0, irq}, 32'h0);
        draw[0] <= 8'h33;
        repeat (4) @(posedge i_clk_sys);
        outs(2'b00);
        check("irq trip", {31'h0, irq}, 32'h1);
        rdc("status", 6'h0c, 32'h24);
        rdc("irq stat", 6'h10, 32'h1f);
        bus(1'b1, 6'h10, 32'h3f);
        check("irq clear", {31'h0, irq}, 32'h0);
        draw[0] <= 8'h00;
        bus(1'b1, 6'h04, 32'hc8);
        $display("test fuse done");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #(20 * 40000);
        mismatches++;
        print_verdict();
    end

    initial begin
        mismatches = 0;
        num_checks = 0;
        i_srst = 1'b1;
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_be = 4'hf;
        avs_writedata = 32'h0;
        key_acc = 1'b0;
        key_ign = 1'b0;
        press = 8'h00;
        draw = '0;
        repeat (4) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        @(posedge i_clk_sys);
        t_reset();
        t_cab();
        t_remote();
        t_off_wins();
        t_start();
        t_fuse();
        print_verdict();
    end
endmodule // dual_three_way_output_control_test
